// ==== hdl/mstby_params.svh ====
// Purpose: constants for the peripheral standby control block
// Assumes: APB slave, 32-bit data, two register words (control and read-only status)
// Notes:   offsets are byte addresses
//
// Summary of operation
// - bit 7 address break run, resets 1
// - bit 6 pulse unit run, resets 0
// - bit 5 two-wire run, resets 0
// - bit 4 pwm b run, resets 0
// - bit 3 event counter run, resets 0
// - bit 2 watchdog run enable, resets 0
// - bit 1 pwm a run, resets 0
// - bit 0 lcd run, resets 0
// - watchdog standby only while active flag 0
// - clearing while active stores 0, watchdog runs
// - flag clear lets stored 0 take effect
`ifndef MSTBY_PARAMS_SVH
`define MSTBY_PARAMS_SVH
`define MSTBY_CTRL2_OFFSET   12'h000
`define MSTBY_STATUS_OFFSET  12'h004
`define MSTBY_CTRL2_RESET    8'h80
`define MSTBY_ADDR_BREAK_BIT 7
`define MSTBY_PULSE_BIT      6
`define MSTBY_TWO_WIRE_BIT   5
`define MSTBY_PWM_B_BIT      4
`define MSTBY_EVENT_CNT_BIT  3
`define MSTBY_WATCHDOG_BIT   2
`define MSTBY_PWM_A_BIT      1
`define MSTBY_LCD_BIT        0
`endif

// ==== hdl/mstby_pkg.sv ====
// Purpose: types for the peripheral standby control block
// Assumes: nothing beyond the params header
// Notes:   state is one packed struct per module
package mstby_pkg;
  typedef struct packed
  {
    logic [7:0] ctrl;
    logic [31:0] prdata;
  } mstby_state_t;
  typedef struct packed
  {
    logic wd_active_s1;
    logic wd_active_s2;
  } mstby_sync_state_t;
endpackage : mstby_pkg

// ==== hdl/mstby_sync.sv ====
// Purpose: two-stage synchroniser for the watchdog active flag
// Assumes: flag comes from a domain not tied to pclk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module mstby_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);
  mstby_pkg::mstby_sync_state_t st;
  mstby_pkg::mstby_sync_state_t next_st;

  always_comb
  begin
    next_st              = st;
    next_st.wd_active_s1 = async_in;
    next_st.wd_active_s2 = st.wd_active_s1;
  end

  // reset to active: assume watchdog running until proven otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '{wd_active_s1: 1'b1, wd_active_s2: 1'b1};
    else
      st <= next_st;
  end

  assign sync_out = st.wd_active_s2;
endmodule : mstby_sync

// ==== hdl/mstby_ctrl.sv ====
// Purpose: peripheral standby control register with watchdog interlock
// Assumes: APB slave, zero wait states, watchdog flag from another domain
// Notes:   clock enables drive external glitch-free gates per peripheral
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "mstby_params.svh"
module mstby_ctrl
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        watchdog_active_flag,
  output logic             addr_break_run,
  output logic             pulse_unit_run,
  output logic             two_wire_run,
  output logic             pwm_b_run,
  output logic             event_counter_run,
  output logic             watchdog_run,
  output logic             pwm_a_run,
  output logic             lcd_run,
  output logic [7:0]       periph_clk_en,
  output logic [7:0]       periph_access_en
);
  mstby_pkg::mstby_state_t st;
  mstby_pkg::mstby_state_t next_st;
  logic                    wd_active;
  logic                    access;
  logic                    hit_ctrl;
  logic                    hit_status;
  logic                    wr_ctrl;
  logic [7:0]              eff_run;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  mstby_sync u_wd_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (watchdog_active_flag),
    .sync_out (wd_active)
  );

  assign access     = psel && penable;
  assign hit_ctrl   = addr_is(paddr, `MSTBY_CTRL2_OFFSET);
  assign hit_status = addr_is(paddr, `MSTBY_STATUS_OFFSET);
  // byte 0 strobe gates the store; other lanes carry nothing
  assign wr_ctrl    = access && pwrite && hit_ctrl && pstrb[0];

  // the stored watchdog bit is software's; the running state also honours the flag
  always_comb
  begin
    eff_run = st.ctrl;
    eff_run[`MSTBY_WATCHDOG_BIT] = st.ctrl[`MSTBY_WATCHDOG_BIT] || wd_active;
  end

  always_comb
  begin
    next_st = st;
    if (wr_ctrl)
      next_st.ctrl = pwdata[7:0];
    if (psel && !penable && !pwrite)
    begin
      if (hit_ctrl)
        next_st.prdata = {24'h000000, st.ctrl};
      else if (hit_status)
        next_st.prdata = {23'h0, wd_active, eff_run};
      else
        next_st.prdata = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '{ctrl: `MSTBY_CTRL2_RESET, prdata: 32'h00000000};
    else
      st <= next_st;
  end

  // read data is latched in setup so it comes from flip-flops
  assign prdata  = st.prdata;
  assign pready  = 1'b1;
  // unmapped addresses answer with an error, writes there are dropped
  assign pslverr = access && !(hit_ctrl || hit_status);

  assign addr_break_run    = eff_run[`MSTBY_ADDR_BREAK_BIT];
  assign pulse_unit_run    = eff_run[`MSTBY_PULSE_BIT];
  assign two_wire_run      = eff_run[`MSTBY_TWO_WIRE_BIT];
  assign pwm_b_run         = eff_run[`MSTBY_PWM_B_BIT];
  assign event_counter_run = eff_run[`MSTBY_EVENT_CNT_BIT];
  assign watchdog_run      = eff_run[`MSTBY_WATCHDOG_BIT];
  assign pwm_a_run         = eff_run[`MSTBY_PWM_A_BIT];
  assign lcd_run           = eff_run[`MSTBY_LCD_BIT];
  // limitation: gating itself is left to a cell outside, this block gives only enables
  assign periph_clk_en     = eff_run;
  assign periph_access_en  = eff_run;

  mstby_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> (st.ctrl == $past(pwdata[7:0])))
    else $error("control write not stored");

  ctrl_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctrl |=> $stable(st.ctrl))
    else $error("control changed without a write");

  read_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_ctrl) |=> (prdata == {24'h0, $past(st.ctrl)}))
    else $error("control read data wrong");

  addr_break_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    addr_break_run == st.ctrl[`MSTBY_ADDR_BREAK_BIT])
    else $error("address break run mismatch");

  pulse_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_unit_run == st.ctrl[`MSTBY_PULSE_BIT])
    else $error("pulse unit run mismatch");

  two_wire_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    two_wire_run == st.ctrl[`MSTBY_TWO_WIRE_BIT])
    else $error("two wire run mismatch");

  pwm_b_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_b_run == st.ctrl[`MSTBY_PWM_B_BIT])
    else $error("pwm b run mismatch");

  event_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    event_counter_run == st.ctrl[`MSTBY_EVENT_CNT_BIT])
    else $error("event counter run mismatch");

  wd_stored_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !pwdata[`MSTBY_WATCHDOG_BIT]) |=> !st.ctrl[`MSTBY_WATCHDOG_BIT])
    else $error("watchdog bit not cleared");

  wd_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[`MSTBY_WATCHDOG_BIT]) |=> watchdog_run)
    else $error("watchdog not released");

  pwm_a_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_a_run == st.ctrl[`MSTBY_PWM_A_BIT])
    else $error("pwm a run mismatch");

  lcd_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st.ctrl[`MSTBY_LCD_BIT] |-> (!lcd_run && !periph_clk_en[0] && !periph_access_en[0]))
    else $error("lcd not gated");

  wd_standby_a: assert property (@(posedge pclk) disable iff (!presetn)
    !watchdog_run |-> (!st.ctrl[`MSTBY_WATCHDOG_BIT] && !wd_active))
    else $error("watchdog parked while active");

  // three samples cover the two synchroniser stages
  wd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (watchdog_active_flag && !st.ctrl[`MSTBY_WATCHDOG_BIT])[*3] |-> watchdog_run)
    else $error("watchdog stopped while active");

  // four samples, since the synchroniser still shows active at the release edge
  wd_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!watchdog_active_flag && !st.ctrl[`MSTBY_WATCHDOG_BIT])[*4] |-> !watchdog_run)
    else $error("cleared bit did not take effect");

  clk_en_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    periph_clk_en == {addr_break_run, pulse_unit_run, two_wire_run, pwm_b_run,
                      event_counter_run, watchdog_run, pwm_a_run, lcd_run})
    else $error("clock enables differ from run outputs");

  access_en_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    periph_access_en == periph_clk_en)
    else $error("access enables differ from clock enables");

  wd_held_c: cover property (@(posedge pclk) disable iff (!presetn)
    wd_active && !st.ctrl[`MSTBY_WATCHDOG_BIT]);
  wd_park_c: cover property (@(posedge pclk) disable iff (!presetn)
    watchdog_run ##1 !watchdog_run);
  ctrl_write_c: cover property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && hit_ctrl);
  bad_addr_c: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  wd_clear_held_c: cover property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && !pwdata[`MSTBY_WATCHDOG_BIT] && wd_active);
endmodule : mstby_ctrl

// ==== test/tb_module_standby_control_two.sv ====
// Purpose: self-checking bench for the peripheral standby control block
// Assumes: zero-wait APB slave, watchdog flag synchronised in two stages
// Notes:   no separate partner; the bench drives every port itself
`timescale 1ns/100ps
`include "mstby_params.svh"
module tb_module_standby_control_two;
  localparam logic [11:0] ctl_a = `MSTBY_CTRL2_OFFSET;
  localparam logic [11:0] sts_a = `MSTBY_STATUS_OFFSET;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wd_flag;
  wire  [7:0]  run;
  logic [7:0]  clk_en;
  logic [7:0]  acc_en;
  logic [31:0] rd;
  logic        err;
  int          mismatches;
  int          n_compared;
  mstby_ctrl u_mstby_ctrl
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_active_flag(wd_flag), .addr_break_run(run[7]),
    .pulse_unit_run(run[6]), .two_wire_run(run[5]), .pwm_b_run(run[4]),
    .event_counter_run(run[3]), .watchdog_run(run[2]), .pwm_a_run(run[1]),
    .lcd_run(run[0]), .periph_clk_en(clk_en), .periph_access_en(acc_en)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until pready is seen high; the idle edge after it keeps
  // back-to-back calls from assigning psel twice in one time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #20000;
    mismatches++;
    end_sim();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, wd_flag} = 5'h00;
    {paddr, pwdata, pstrb} = {12'h000, 32'h0000_0000, 4'hF};
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({24'h0, run}, 32'h80);
    apb(1'b0, ctl_a, 32'h0);
    chk(rd, {24'h0, `MSTBY_CTRL2_RESET});
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, ctl_a, 32'h1 << i);
      apb(1'b0, ctl_a, 32'h0);
      chk(rd, 32'h1 << i);
      chk({24'h0, run}, 32'h1 << i);
      chk({24'h0, clk_en}, 32'h1 << i);
      chk({24'h0, acc_en}, 32'h1 << i);
    end
    $display("test single bits done");
    pstrb <= 4'hE;
    apb(1'b1, ctl_a, 32'hFF);
    pstrb <= 4'hF;
    apb(1'b1, 12'h008, 32'hFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, sts_a, 32'hFF);
    apb(1'b0, ctl_a, 32'h0);
    chk(rd, 32'h80);
    chk({31'h0, err}, 32'h0);
    $display("test refused writes done");
    apb(1'b1, ctl_a, 32'h04);
    wd_flag <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, ctl_a, 32'h00);
    apb(1'b0, ctl_a, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, run[2]}, 32'h1);
    apb(1'b0, sts_a, 32'h0);
    chk(rd, 32'h104);
    wd_flag <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({24'h0, run}, 32'h0);
    chk({24'h0, clk_en}, 32'h0);
    chk({24'h0, acc_en}, 32'h0);
    apb(1'b0, sts_a, 32'h0);
    chk(rd, 32'h0);
    $display("test watchdog interlock done");
    apb(1'b1, ctl_a, 32'h7F);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({24'h0, run}, 32'h84);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({24'h0, run}, 32'h80);
    apb(1'b0, ctl_a, 32'h0);
    chk(rd, {24'h0, `MSTBY_CTRL2_RESET});
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : tb_module_standby_control_two
